// File: dacclk_defines.svh
`ifndef DACCLK_DEFINES_SVH
`define DACCLK_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets within a page
// ----------------------------------------------------------------------------
`define DACCLK_OFS_PAGE       8'h00
`define DACCLK_OFS_SWRST      8'h01
`define DACCLK_OFS_CLKSEL     8'h04
`define DACCLK_OFS_NDIV       8'h0B
`define DACCLK_OFS_MDIV       8'h0C
`define DACCLK_OFS_OSR_HI     8'h0D
`define DACCLK_OFS_OSR_LO     8'h0E
`define DACCLK_OFS_WORDLEN    8'h1B
`define DACCLK_OFS_PRB        8'h3C
`define DACCLK_OFS_PORCTL     8'h01
`define DACCLK_OFS_TIER       8'h03
`define DACCLK_OFS_STATUS     8'h3F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DACCLK_BIT_SWRST      0
`define DACCLK_BIT_CLKSEL     0
`define DACCLK_BIT_DIV_PWR    7
`define DACCLK_BIT_POR_DIS    3
`define DACCLK_WL_LSB         4
`define DACCLK_WL_MSB         5
`define DACCLK_TIER_LSB       2
`define DACCLK_TIER_MSB       4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DACCLK_RST_NDIV       7'h01
`define DACCLK_RST_MDIV       7'h01
`define DACCLK_RST_OSR        10'h080
`define DACCLK_RST_WORDLEN    2'h0
`define DACCLK_RST_PRB        5'h01
`define DACCLK_RST_TIER       3'h0

// ----------------------------------------------------------------------------
// Tier and word length encodings
// ----------------------------------------------------------------------------
`define DACCLK_TIER_ONE_CODE  3'h2
`define DACCLK_TIER_TWO_CODE  3'h1
`define DACCLK_TIER_LOW_CODE  3'h0
`define DACCLK_WL_16_CODE     2'h0

`endif

// File: dacclk_pkg.sv
package dacclk_pkg;

  typedef enum logic {
    DACCLK_PAGE_ZERO = 1'b0,
    DACCLK_PAGE_ONE  = 1'b1
  } dacclk_page_e;

  typedef enum logic [1:0] {
    DACCLK_WL_16 = 2'b00,
    DACCLK_WL_20 = 2'b01,
    DACCLK_WL_24 = 2'b10,
    DACCLK_WL_32 = 2'b11
  } dacclk_wordlen_e;

  typedef logic [7:0] dacclk_byte_t;

endpackage : dacclk_pkg

// File: dacclk_div_if.sv
interface dacclk_div_if #(
  parameter int W = 8
);
  logic         enable;
  logic [W-1:0] divisor;
  logic         tick_in;
  logic         tick_out;
  logic         running;

  modport ctrl (output enable, output divisor, output tick_in, input tick_out, input running);
  modport div  (input enable, input divisor, input tick_in, output tick_out, output running);
endinterface : dacclk_div_if

// File: dacclk_div.sv
module dacclk_div #(
  parameter int W = 8
) (
  input wire logic   core_clk,
  input wire logic   rst_n,
  dacclk_div_if.div  bus
);

  logic [W-1:0] count_r;
  logic         tick_r;
  logic         run_r;

  // --------------------------------------------------------------------------
  // Divide incoming ticks by the programmed divisor.
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      tick_r  <= 1'b0;
    end else if (!bus.enable) begin
      count_r <= '0;
      tick_r  <= 1'b0;
    end else if (bus.tick_in) begin
      // A divisor lowered below the running count wraps at once instead of
      // running the counter all the way round.
      if (count_r >= W'(bus.divisor - W'(1))) begin
        count_r <= '0;
        tick_r  <= 1'b1;
      end else begin
        count_r <= W'(count_r + W'(1));
        tick_r  <= 1'b0;
      end
    end else begin
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= bus.enable;
    end
  end

  assign bus.tick_out = tick_r;
  assign bus.running  = run_r;

endmodule : dacclk_div

// File: dacclk_ctrl.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "dacclk_defines.svh"

module dacclk_ctrl
  import dacclk_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       power_good,
  input  wire logic       sysclk_tick,
  input  wire logic       pll_tick,
  output logic            sample_tick,
  output logic            por_enable,
  output logic      [2:0] tier_code,
  output logic      [1:0] word_len_code,
  output logic      [4:0] block_select
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  dacclk_page_e page_r;
  logic         clk_sel_r;
  logic         n_pwr_r;
  logic [6:0]   n_val_r;
  logic         m_pwr_r;
  logic [6:0]   m_val_r;
  logic [9:0]   osr_r;
  logic [1:0]   wl_r;
  logic [4:0]   prb_r;
  logic         por_en_r;
  logic [2:0]   tier_r;
  logic         pg_prev_r;
  logic         reload_r;
  logic         src_tick_r;
  logic [7:0]   rdata_r;

  logic         wr0;
  logic         wr1;
  logic         por_evt;
  logic         swrst_evt;

  dacclk_div_if #(.W(8))  n_if ();
  dacclk_div_if #(.W(8))  m_if ();
  dacclk_div_if #(.W(11)) o_if ();

  assign wr0 = reg_wr && (page_r == DACCLK_PAGE_ZERO);
  assign wr1 = reg_wr && (page_r == DACCLK_PAGE_ONE);

  // --------------------------------------------------------------------------
  // Reset sources
  // --------------------------------------------------------------------------
  // power-up reload
  assign por_evt   = power_good && !pg_prev_r && por_en_r;
  assign swrst_evt = wr0 && (reg_addr == `DACCLK_OFS_SWRST) && reg_wdata[`DACCLK_BIT_SWRST];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // A supply already good at reset release is not a fresh power-up;
      // a false edge here would wipe the first writes.
      pg_prev_r <= 1'b1;
      reload_r  <= 1'b0;
    end else begin
      pg_prev_r <= power_good;
      reload_r  <= por_evt || swrst_evt;
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // The page register survives a software reset so the host stays addressed.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= DACCLK_PAGE_ZERO;
    end else if (reg_wr && (reg_addr == `DACCLK_OFS_PAGE)) begin
      page_r <= dacclk_page_e'(reg_wdata[0]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_r <= 1'b0;
      n_pwr_r   <= 1'b0;
      n_val_r   <= `DACCLK_RST_NDIV;
      m_pwr_r   <= 1'b0;
      m_val_r   <= `DACCLK_RST_MDIV;
      osr_r     <= `DACCLK_RST_OSR;
      wl_r      <= `DACCLK_RST_WORDLEN;
      prb_r     <= `DACCLK_RST_PRB;
    end else if (reload_r) begin
      clk_sel_r <= 1'b0;
      n_pwr_r   <= 1'b0;
      n_val_r   <= `DACCLK_RST_NDIV;
      m_pwr_r   <= 1'b0;
      m_val_r   <= `DACCLK_RST_MDIV;
      osr_r     <= `DACCLK_RST_OSR;
      wl_r      <= `DACCLK_RST_WORDLEN;
      prb_r     <= `DACCLK_RST_PRB;
    end else if (wr0) begin
      if (reg_addr == `DACCLK_OFS_CLKSEL) begin
        clk_sel_r <= reg_wdata[`DACCLK_BIT_CLKSEL];
      end else if (reg_addr == `DACCLK_OFS_NDIV) begin
        n_pwr_r <= reg_wdata[`DACCLK_BIT_DIV_PWR];
        n_val_r <= reg_wdata[6:0];
      end else if (reg_addr == `DACCLK_OFS_MDIV) begin
        m_pwr_r <= reg_wdata[`DACCLK_BIT_DIV_PWR];
        m_val_r <= reg_wdata[6:0];
      end else if (reg_addr == `DACCLK_OFS_OSR_HI) begin
        osr_r[9:8] <= reg_wdata[1:0];
      end else if (reg_addr == `DACCLK_OFS_OSR_LO) begin
        osr_r[7:0] <= reg_wdata;
      end else if (reg_addr == `DACCLK_OFS_WORDLEN) begin
        wl_r <= reg_wdata[`DACCLK_WL_MSB:`DACCLK_WL_LSB];
      end else if (reg_addr == `DACCLK_OFS_PRB) begin
        prb_r <= reg_wdata[4:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_en_r <= 1'b1;
      tier_r   <= `DACCLK_RST_TIER;
    end else if (reload_r) begin
      por_en_r <= 1'b1;
      tier_r   <= `DACCLK_RST_TIER;
    end else if (wr1) begin
      if (reg_addr == `DACCLK_OFS_PORCTL) begin
        por_en_r <= !reg_wdata[`DACCLK_BIT_POR_DIS];
      end else if (reg_addr == `DACCLK_OFS_TIER) begin
        tier_r <= reg_wdata[`DACCLK_TIER_MSB:`DACCLK_TIER_LSB];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock chain
  // --------------------------------------------------------------------------
  // source multiplexer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_tick_r <= 1'b0;
    end else begin
      src_tick_r <= clk_sel_r ? pll_tick : sysclk_tick;
    end
  end

  assign n_if.divisor = {(n_val_r == 7'h00), n_val_r};
  assign m_if.divisor = {(m_val_r == 7'h00), m_val_r};
  // Zero in the oversampling field stands for 1024.
  assign o_if.divisor = {(osr_r == 10'h000), osr_r};

  assign n_if.enable  = n_pwr_r;
  assign n_if.tick_in = src_tick_r;
  assign m_if.enable  = m_pwr_r && n_pwr_r;
  assign m_if.tick_in = n_if.tick_out;
  assign o_if.enable  = m_pwr_r && n_pwr_r;
  assign o_if.tick_in = m_if.tick_out;

  dacclk_div #(.W(8)) u_ndiv (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (n_if.div)
  );

  dacclk_div #(.W(8)) u_mdiv (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (m_if.div)
  );

  dacclk_div #(.W(11)) u_osr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (o_if.div)
  );

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Reads only return data; no register changes on a read.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (!reg_rd) begin
      rdata_r <= 8'h00;
    end else if (reg_addr == `DACCLK_OFS_PAGE) begin
      rdata_r <= {7'h00, page_r};
    end else if (page_r == DACCLK_PAGE_ZERO) begin
      if (reg_addr == `DACCLK_OFS_CLKSEL) begin
        rdata_r <= {7'h00, clk_sel_r};
      end else if (reg_addr == `DACCLK_OFS_NDIV) begin
        rdata_r <= {n_pwr_r, n_val_r};
      end else if (reg_addr == `DACCLK_OFS_MDIV) begin
        rdata_r <= {m_pwr_r, m_val_r};
      end else if (reg_addr == `DACCLK_OFS_OSR_HI) begin
        rdata_r <= {6'h00, osr_r[9:8]};
      end else if (reg_addr == `DACCLK_OFS_OSR_LO) begin
        rdata_r <= osr_r[7:0];
      end else if (reg_addr == `DACCLK_OFS_WORDLEN) begin
        rdata_r <= {2'h0, wl_r, 4'h0};
      end else if (reg_addr == `DACCLK_OFS_PRB) begin
        rdata_r <= {3'h0, prb_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      if (reg_addr == `DACCLK_OFS_PORCTL) begin
        rdata_r <= {4'h0, ~por_en_r, 3'h0};
      end else if (reg_addr == `DACCLK_OFS_TIER) begin
        rdata_r <= {3'h0, tier_r, 2'h0};
      end else if (reg_addr == `DACCLK_OFS_STATUS) begin
        rdata_r <= {n_if.running, m_if.running, o_if.running, clk_sel_r, 4'h0};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // The sample tick is already a flop inside the last divider; a re-register
  // here would only add latency, so it is passed as is.
  assign sample_tick   = o_if.tick_out;
  assign reg_rdata     = rdata_r;
  assign por_enable    = por_en_r;
  assign tier_code     = tier_r;
  assign word_len_code = wl_r;
  assign block_select  = prb_r;

endmodule : dacclk_ctrl

// File: dacclk_ctrl_sva.sv
module dacclk_ctrl_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       power_good,
  input wire logic       sysclk_tick,
  input wire logic       pll_tick,
  input wire logic       sample_tick,
  input wire logic       por_enable,
  input wire logic [2:0] tier_code,
  input wire logic [1:0] word_len_code,
  input wire logic [4:0] block_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Shadow of page and source selection.
  // ---------------------------------------------------------------
  logic       page_r;
  logic       sel_r;
  logic [7:0] wd_r;
  logic [3:0] quiet_r;
  wire        wr0 = reg_wr && !page_r;
  wire        wr1 = reg_wr && page_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= 1'b0;
      sel_r  <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      page_r <= reg_wdata[0];
    end else if (wr0 && reg_addr == 8'h04) begin
      sel_r <= reg_wdata[0];
    end
  end
  always_ff @(posedge core_clk) begin
    wd_r <= reg_wdata;
  end
  // A select write restarts the count, since old ticks may still be in flight.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_r <= 4'h0;
    end else if ((sel_r ? pll_tick : sysclk_tick) || (wr0 && reg_addr == 8'h04)) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_POR_WRITE:
    assert property (wr1 && reg_addr == 8'h01 |=> por_enable == !wd_r[3]) else $error("por bit");
  AST_TIER_WRITE:
    assert property (wr1 && reg_addr == 8'h03 |=> tier_code == wd_r[4:2]) else $error("tier");
  AST_WL_WRITE:
    assert property (wr0 && reg_addr == 8'h1B |=> word_len_code == wd_r[5:4]) else $error("wl");
  AST_BLOCK_WRITE:
    assert property (wr0 && reg_addr == 8'h3C |=> block_select == wd_r[4:0]) else $error("blk");
  AST_POR_RELOAD:
    assert property ($rose(power_good) && por_enable |-> ##2 (tier_code == 3'h0
      && word_len_code == 2'h0 && block_select == 5'h01 && por_enable)) else $error("reload");
  AST_POR_BLOCKED:
    assert property ($rose(power_good) && !por_enable |-> ##2 (!por_enable
      && tier_code == $past(tier_code, 2))) else $error("reload while disabled");
  AST_SRC_QUIET:
    assert property (quiet_r >= 4'h8 |-> !sample_tick) else $error("tick without source");
  AST_CHAIN_OFF:
    assert property (wr0 && reg_addr == 8'h0B && !reg_wdata[7] |-> ##6 !sample_tick [*8])
      else $error("tick with divider off");
endmodule : dacclk_ctrl_chk

bind dacclk_ctrl dacclk_ctrl_chk i_dacclk_ctrl_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .power_good, .sysclk_tick, .pll_tick, .sample_tick,
  .por_enable, .tier_code, .word_len_code, .block_select);

// File: dacclk_src_model.sv
module dacclk_src_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] sys_per,
  input  wire logic [3:0] pll_per,
  output logic            sysclk_tick,
  output logic            pll_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Source clocks; a period of zero stops that source.
  // ---------------------------------------------------------------
  logic [3:0] sys_cnt_r;
  logic [3:0] pll_cnt_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_cnt_r   <= 4'h0;
      sysclk_tick <= 1'b0;
    end else begin
      sysclk_tick <= (sys_per != 4'h0) && (sys_cnt_r == 4'h0);
      sys_cnt_r   <= (sys_cnt_r + 4'h1 >= sys_per) ? 4'h0 : sys_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_cnt_r <= 4'h0;
      pll_tick  <= 1'b0;
    end else begin
      pll_tick  <= (pll_per != 4'h0) && (pll_cnt_r == 4'h0);
      pll_cnt_r <= (pll_cnt_r + 4'h1 >= pll_per) ? 4'h0 : pll_cnt_r + 4'h1;
    end
  end
endmodule : dacclk_src_model

// File: dac_clock_and_setup_control_test.sv
module dac_clock_and_setup_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Bench signals and instances.
  // ---------------------------------------------------------------
  localparam logic [7:0] DA [7] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h1B, 8'h3C, 8'h55};
  localparam logic [7:0] DV [7] = '{8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h01, 8'h00};
  logic       core_clk, rst_n, reg_wr, reg_rd, power_good, rd_d;
  logic       sysclk_tick, pll_tick, sample_tick, por_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] tier_code;
  logic [1:0] word_len_code;
  logic [4:0] block_select;
  logic [3:0] sys_per, pll_per;
  logic [7:0] exp_q [$];
  int         err_total, samples_checked, cyc, n_ticks, last_t, gap;
  dacclk_ctrl i_dacclk_ctrl (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .power_good, .sysclk_tick, .pll_tick, .sample_tick, .por_enable,
    .tier_code, .word_len_code, .block_select);
  dacclk_src_model i_dacclk_src_model (.core_clk, .rst_n, .sys_per, .pll_per,
    .sysclk_tick, .pll_tick);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic pulse_power;
    @(posedge core_clk);
    power_good <= 1'b0;
    repeat (3) @(posedge core_clk);
    power_good <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : pulse_power
  task automatic wait_ticks(input int k);
    int t0;
    t0 = n_ticks;
    while (n_ticks < t0 + k) @(posedge core_clk);
    #1;
  endtask : wait_ticks
  always @(posedge core_clk) begin
    cyc  <= cyc + 1;
    rd_d <= reg_rd;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  always @(negedge core_clk) begin
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    if (sample_tick) begin
      gap    = cyc - last_t;
      last_t = cyc;
      n_ticks++;
    end
  end
  initial begin
    logic [7:0] v;
    int         n, m, o, s;
    {rst_n, reg_wr, reg_rd, rd_d, reg_addr, reg_wdata} = '0;
    {cyc, n_ticks, last_t, gap, err_total, samples_checked} = '0;
    {sys_per, pll_per} = '0;
    power_good = 1'b1;
    void'($urandom(64));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(por_enable, 1);
    for (int i = 0; i < 7; i++) rd(DA[i], DV[i]);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    $display("defaults done");
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h80 : 8'($urandom);
      wr(8'h0B, v);
      wr(8'h0C, ~v);
      rd(8'h0B, v);
      rd(8'h0C, ~v);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h1B, 8'(i << 4));
      chk(word_len_code, i);
      rd(8'h1B, 8'(i << 4));
    end
    v = 8'($urandom) & 8'h1F;
    wr(8'h3C, v);
    chk(block_select, v[4:0]);
    wr(8'h00, 8'h01);
    for (int i = 2; i >= 0; i--) begin
      wr(8'h03, (8'($urandom) & 8'hE3) | 8'(i << 2));
      chk(tier_code, i);
    end
    $display("fields done");
    sys_per <= 4'h1;
    pll_per <= 4'h3;
    wr(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      n = 1 + $urandom % 4;
      m = 1 + $urandom % 4;
      s = i % 2;
      o = (s ? 8 : 4) * (1 + $urandom % 2);
      wr(8'h04, 8'(s));
      wr(8'h0B, 8'h80 | 8'(n));
      wr(8'h0C, 8'h80 | 8'(m));
      wr(8'h0D, 8'h00);
      wr(8'h0E, 8'(o));
      wait_ticks(3);
      chk(gap, n * m * o * (s ? 3 : 1));
    end
    wr(8'h00, 8'h01);
    rd(8'h3F, 8'hF0);
    wr(8'h00, 8'h00);
    wr(8'h0B, 8'h01);
    repeat (10) @(posedge core_clk);
    n = n_ticks;
    repeat (300) @(posedge core_clk);
    chk(n_ticks, n);
    {sys_per, pll_per} <= '0;
    repeat (20) @(posedge core_clk);
    $display("clock chain done");
    wr(8'h00, 8'h01);
    wr(8'h03, 8'h08);
    wr(8'h01, 8'h08);
    chk(por_enable, 0);
    pulse_power();
    chk(tier_code, 2);
    wr(8'h01, 8'h00);
    chk(por_enable, 1);
    pulse_power();
    chk(tier_code, 0);
    chk(word_len_code, 0);
    chk(block_select, 1);
    wr(8'h00, 8'h00);
    rd(8'h0B, 8'h01);
    wr(8'h3C, 8'h1F);
    wr(8'h01, 8'h01);
    repeat (2) @(posedge core_clk);
    #1;
    chk(block_select, 1);
    repeat (3) @(posedge core_clk);
    $display("power-on reload done");
    end_sim();
  end
endmodule : dac_clock_and_setup_control_test
